// >>> rtl/tmc_pkg.sv
// package for the 16-bit timer/counter: register map, field positions,
// reset values, state layout and divider counts.
// assumes a classic wishbone slave with byte addresses on a 32-bit data bus.
package tmc_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_COUNT_LOW  = 8'h00;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
    localparam logic [7:0] OFF_CONTROL    = 8'h08;
    localparam logic [7:0] OFF_STATUS     = 8'h0c;
    localparam logic [7:0] OFF_ENABLE     = 8'h10;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTL_WIDE     = 7;
    localparam int CTL_PSEL_HI  = 5;
    localparam int CTL_PSEL_LO  = 4;
    localparam int CTL_SYNC_DIS = 2;
    localparam int CTL_CS       = 1;
    localparam int CTL_ON       = 0;
    localparam int STS_FLAG     = 0;
    localparam int ENA_IE       = 0;
    localparam int ENA_AUX      = 1;

    // ----------------------------------------------------------------
    // codes and counts
    // ----------------------------------------------------------------
    localparam logic [3:0]  CMP_MODE_SPECIAL = 4'hb;
    localparam logic [1:0]  QDIV_LAST        = 2'h3;
    localparam logic [15:0] COUNT_MAX        = 16'hffff;
    localparam logic        SYNC_PREV_RESET  = 1'b1;

    // ----------------------------------------------------------------
    // state of the top module
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] count;
        logic [7:0]  hbuf;
        logic        wide;
        logic [1:0]  psel;
        logic        sync_dis;
        logic        cs;
        logic        on;
        logic        flag;
        logic        ie;
        logic        aux_en;
        logic [1:0]  qdiv;
        logic        ack;
        logic [31:0] dat;
    } tmc_state_s;

    localparam tmc_state_s ST_RESET = '0;

endpackage

// >>> rtl/tmc_sync_edge.sv
// two-flop synchronisers for asynchronous pins, with rising-edge pulses.
// assumes inputs are unrelated to clk; outputs are in the clk domain.
`timescale 1ns/1ps
module tmc_sync_edge #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] prev;
    } tmc_sync_s;

    tmc_sync_s st_reg;
    tmc_sync_s st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.s1   = async_in;
        st_next.s2   = st_reg.s1;
        st_next.prev = st_reg.s2;
    end

    // prev starts high, but s2 resets low, so a pin already high at reset
    // release still gives one counted rise once it has passed the two flops
    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg.s1   <= '0;
            st_reg.s2   <= '0;
            st_reg.prev <= {W{tmc_pkg::SYNC_PREV_RESET}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.s2;
    assign rise  = st_reg.s2 & ~st_reg.prev;

endmodule

// >>> rtl/tmc_prescaler.sv
// input prescaler: passes one of every 1, 2, 4 or 8 source pulses.
// assumes en is a one-cycle pulse on clk; clr wins over en at phase, but tick is not gated by clr.
`timescale 1ns/1ps
module tmc_prescaler #(
    parameter int PW = 3
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          en,
    input  wire logic          clr,
    input  wire logic [1:0]    sel,
    output logic               tick,
    output logic      [PW-1:0] phase
);
    typedef struct packed {
        logic [PW-1:0] cnt;
    } tmc_pre_s;

    tmc_pre_s    st_reg;
    tmc_pre_s    st_next;
    logic [PW-1:0] mask;

    assign mask = PW'((1 << sel) - 1);
    assign tick = en && ((st_reg.cnt & mask) == mask);

    always_comb begin
        st_next = st_reg;
        if (clr) begin
            st_next.cnt = '0;
        end else if (en) begin
            st_next.cnt = (st_reg.cnt & mask) == mask ? '0 : st_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign phase = st_reg.cnt;

endmodule

// >>> rtl/tmc_timer.sv
// 16-bit timer/counter with prescaler, buffered 16-bit access, overflow
// flag and special-event reset, reached over classic wishbone.
// assumes pins are asynchronous to clk and the compare unit runs on clk.
`timescale 1ns/1ps
module tmc_timer (
    input  wire logic        clk,
    input  wire logic        reset,
    // wishbone slave
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    // clock sources and shared pins
    input  wire logic        external_clock_pin,
    input  wire logic        aux_osc_clk,
    input  wire logic [1:0]  aux_pin_level,
    input  wire logic [1:0]  port_oe_request,
    output logic      [1:0]  aux_pin_oe,
    output logic      [1:0]  port_read_value,
    // compare unit
    input  wire logic [3:0]  capture_compare_mode,
    input  wire logic        compare_match,
    // interrupt request
    output logic             overflow_irq
);

    // ----------------------------------------------------------------
    // state and decode
    // ----------------------------------------------------------------
    tmc_pkg::tmc_state_s st_reg;
    tmc_pkg::tmc_state_s st_next;

    logic       acc;
    logic       wr;
    logic       rd;
    logic       lo_wr;
    logic       hi_wr;
    logic       lo_rd;
    logic       ctl_wr;
    logic       sts_wr;
    logic       ena_wr;
    logic [7:0] wdat;
    logic       quarter;
    logic       src_en;
    logic       trig_eff;
    logic       cnt_wr;
    logic       tick;
    logic       wrap;
    logic [2:0] pre_phase;
    logic [3:0] sync_level;
    logic [3:0] sync_rise;

    assign acc    = wb_cyc_i && wb_stb_i && !st_reg.ack;
    assign wr     = acc && wb_we_i && wb_sel_i[0];
    assign rd     = acc && !wb_we_i;
    assign wdat   = wb_dat_i[7:0];
    assign lo_wr  = wr && wb_adr_i == tmc_pkg::OFF_COUNT_LOW;
    assign hi_wr  = wr && wb_adr_i == tmc_pkg::OFF_COUNT_HIGH;
    assign lo_rd  = rd && wb_adr_i == tmc_pkg::OFF_COUNT_LOW;
    assign ctl_wr = wr && wb_adr_i == tmc_pkg::OFF_CONTROL;
    assign sts_wr = wr && wb_adr_i == tmc_pkg::OFF_STATUS;
    assign ena_wr = wr && wb_adr_i == tmc_pkg::OFF_ENABLE;

    // ----------------------------------------------------------------
    // clock sources
    // ----------------------------------------------------------------
    // pins pass two flops; edges are counted only in the clk domain, so
    // the asynchronous mode differs from the synchronised one only in
    // refusing the special-event reset
    tmc_sync_edge #(
        .W (4)
    ) u_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in ({aux_pin_level, aux_osc_clk, external_clock_pin}),
        .level    (sync_level),
        .rise     (sync_rise)
    );

    assign quarter = st_reg.qdiv == tmc_pkg::QDIV_LAST;

    always_comb begin
        if (st_reg.cs) begin
            src_en = st_reg.aux_en ? sync_rise[1] : sync_rise[0];
        end else begin
            src_en = quarter;
        end
    end

    // a stopped counter feeds no pulses to the prescaler either
    tmc_prescaler #(
        .PW (3)
    ) u_pre (
        .clk   (clk),
        .reset (reset),
        .en    (src_en && st_reg.on),
        .clr   (lo_wr || trig_eff),
        .sel   (st_reg.psel),
        .tick  (tick),
        .phase (pre_phase)
    );

    // ----------------------------------------------------------------
    // special event and count update
    // ----------------------------------------------------------------
    assign trig_eff = compare_match && capture_compare_mode == tmc_pkg::CMP_MODE_SPECIAL
                      && !(st_reg.cs && st_reg.sync_dis);
    assign cnt_wr   = lo_wr || (hi_wr && !st_reg.wide);
    assign wrap     = tick && st_reg.count == tmc_pkg::COUNT_MAX && !cnt_wr && !trig_eff;

    always_comb begin
        st_next      = st_reg;
        st_next.qdiv = st_reg.qdiv + 2'h1;
        st_next.ack  = acc;

        if (hi_wr && st_reg.wide) begin
            st_next.hbuf = wdat;
        end
        if (lo_rd && st_reg.wide) begin
            st_next.hbuf = st_reg.count[15:8];
        end

        if (lo_wr) begin
            if (st_reg.wide) begin
                st_next.count = {st_reg.hbuf, wdat};
            end else begin
                st_next.count = {st_reg.count[15:8], wdat};
            end
        end else if (hi_wr && !st_reg.wide) begin
            st_next.count[15:8] = wdat;
        end else if (trig_eff) begin
            st_next.count = '0;
        end else if (tick) begin
            st_next.count = st_reg.count + 16'h0001;
        end

        if (ctl_wr) begin
            st_next.wide     = wdat[tmc_pkg::CTL_WIDE];
            st_next.psel     = wdat[tmc_pkg::CTL_PSEL_HI:tmc_pkg::CTL_PSEL_LO];
            st_next.sync_dis = wdat[tmc_pkg::CTL_SYNC_DIS];
            st_next.cs       = wdat[tmc_pkg::CTL_CS];
            st_next.on       = wdat[tmc_pkg::CTL_ON];
        end
        if (ena_wr) begin
            st_next.ie     = wdat[tmc_pkg::ENA_IE];
            st_next.aux_en = wdat[tmc_pkg::ENA_AUX];
        end

        // write one to clear; a wrap in the same cycle still lands
        if (sts_wr && wdat[tmc_pkg::STS_FLAG]) begin
            st_next.flag = 1'b0;
        end
        if (wrap) begin
            st_next.flag = 1'b1;
        end

        if (rd) begin
            st_next.dat = '0;
            case (wb_adr_i)
                tmc_pkg::OFF_COUNT_LOW: begin
                    st_next.dat[7:0] = st_reg.count[7:0];
                end
                tmc_pkg::OFF_COUNT_HIGH: begin
                    st_next.dat[7:0] = st_reg.wide ? st_reg.hbuf : st_reg.count[15:8];
                end
                tmc_pkg::OFF_CONTROL: begin
                    st_next.dat[tmc_pkg::CTL_WIDE]     = st_reg.wide;
                    st_next.dat[tmc_pkg::CTL_PSEL_HI:tmc_pkg::CTL_PSEL_LO] = st_reg.psel;
                    st_next.dat[tmc_pkg::CTL_SYNC_DIS] = st_reg.sync_dis;
                    st_next.dat[tmc_pkg::CTL_CS]       = st_reg.cs;
                    st_next.dat[tmc_pkg::CTL_ON]       = st_reg.on;
                end
                tmc_pkg::OFF_STATUS: begin
                    st_next.dat[tmc_pkg::STS_FLAG] = st_reg.flag;
                end
                tmc_pkg::OFF_ENABLE: begin
                    st_next.dat[tmc_pkg::ENA_IE]  = st_reg.ie;
                    st_next.dat[tmc_pkg::ENA_AUX] = st_reg.aux_en;
                end
                default: begin
                    st_next.dat = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= tmc_pkg::ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_ack_o        = st_reg.ack;
    assign wb_dat_o        = st_reg.dat;
    assign overflow_irq    = st_reg.flag && st_reg.ie;
    assign aux_pin_oe      = st_reg.aux_en ? 2'h0 : port_oe_request;
    assign port_read_value = st_reg.aux_en ? 2'h0 : sync_level[3:2];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_wrap;
        @(posedge clk) disable iff (reset)
        wrap |=> st_reg.count == 16'h0000 && st_reg.flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap with flag set");

    property p_flag_sticky;
        @(posedge clk) disable iff (reset)
        st_reg.flag && !(sts_wr && wdat[tmc_pkg::STS_FLAG]) |=> st_reg.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag dropped on its own");

    property p_irq;
        @(posedge clk) disable iff (reset)
        wrap && st_reg.ie && !ena_wr |=> overflow_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled overflow raised no request");

    property p_hold;
        @(posedge clk) disable iff (reset)
        !st_reg.on && !cnt_wr && !trig_eff && !ctl_wr |=> $stable(st_reg.count);
    endproperty
    a_hold: assert property (p_hold) else $error("stopped counter moved");

    property p_trig;
        @(posedge clk) disable iff (reset)
        trig_eff && !cnt_wr && !sts_wr |=> st_reg.count == 16'h0000 && st_reg.flag == $past(st_reg.flag);
    endproperty
    a_trig: assert property (p_trig) else $error("special event reset wrong");

    property p_write_wins;
        @(posedge clk) disable iff (reset)
        trig_eff && lo_wr && st_reg.wide |=> st_reg.count == {$past(st_reg.hbuf), $past(wdat)};
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("write lost to special event");

    property p_snapshot;
        @(posedge clk) disable iff (reset)
        lo_rd && st_reg.wide |=> st_reg.hbuf == $past(st_reg.count[15:8]);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("high byte not captured on low read");

    property p_hi_buffered;
        @(posedge clk) disable iff (reset)
        hi_wr && st_reg.wide && !tick && !trig_eff |=> $stable(st_reg.count);
    endproperty
    a_hi_buffered: assert property (p_hi_buffered) else $error("buffered high write hit the count");

    property p_pre_clear;
        @(posedge clk) disable iff (reset)
        lo_wr |=> pre_phase == 3'h0;
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("low write left prescaler running");

    property p_pins;
        @(posedge clk) disable iff (reset)
        st_reg.aux_en |-> aux_pin_oe == 2'h0 && port_read_value == 2'h0;
    endproperty
    a_pins: assert property (p_pins) else $error("aux pins driven or read nonzero");

    property p_quarter;
        @(posedge clk) disable iff (reset)
        !st_reg.cs && st_reg.on && st_reg.psel == 2'h0 && quarter && !cnt_wr && !trig_eff
        |=> st_reg.count == $past(st_reg.count) + 16'h0001;
    endproperty
    a_quarter: assert property (p_quarter) else $error("internal clock pulse not counted");

    property p_aux_count;
        @(posedge clk) disable iff (reset)
        st_reg.cs && st_reg.aux_en && st_reg.on && st_reg.psel == 2'h0 && sync_rise[1] && !cnt_wr && !trig_eff
        |=> st_reg.count == $past(st_reg.count) + 16'h0001;
    endproperty
    a_aux_count: assert property (p_aux_count) else $error("aux oscillator edge not counted");

    property p_aux_only;
        @(posedge clk) disable iff (reset)
        st_reg.cs && st_reg.aux_en && !sync_rise[1] && !cnt_wr && !trig_eff
        |=> $stable(st_reg.count);
    endproperty
    a_aux_only: assert property (p_aux_only) else $error("count moved without an aux oscillator edge");

    property p_irq_masked;
        @(posedge clk) disable iff (reset)
        !st_reg.ie
        |-> !overflow_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked overflow raised a request");

    property p_wide_load;
        @(posedge clk) disable iff (reset)
        lo_wr && st_reg.wide
        |=> st_reg.count == {$past(st_reg.hbuf), $past(wdat)};
    endproperty
    a_wide_load: assert property (p_wide_load) else $error("low write did not load both bytes");

    property p_live_high;
        @(posedge clk) disable iff (reset)
        hi_wr && !st_reg.wide
        |=> st_reg.count[15:8] == $past(wdat);
    endproperty
    a_live_high: assert property (p_live_high) else $error("direct high write missed the count");

    property p_buffer_read;
        @(posedge clk) disable iff (reset)
        rd && wb_adr_i == tmc_pkg::OFF_COUNT_HIGH && st_reg.wide
        |=> wb_dat_o == {24'h0, $past(st_reg.hbuf)};
    endproperty
    a_buffer_read: assert property (p_buffer_read) else $error("high read bypassed the buffer");

    property p_stop_no_flag;
        @(posedge clk) disable iff (reset)
        !st_reg.on && !st_reg.flag
        |=> !st_reg.flag;
    endproperty
    a_stop_no_flag: assert property (p_stop_no_flag) else $error("stopped counter raised overflow");

endmodule

// >>> tb/tmc_clk_src.sv
// far side of the count input: external clock pin and aux oscillator.
// assumes one-cycle requests on clk; each request gives one rising edge.
`timescale 1ns/1ps
module tmc_clk_src (
    input  wire logic clk,
    input  wire logic ext_req,
    input  wire logic aux_req,
    output logic      ext_pin,
    output logic      aux_clk
);
    int ext_n = 0;
    int aux_n = 0;
    initial begin
        ext_pin = 1'b0;
        aux_clk = 1'b0;
    end
    // ---------------------------------------------------------------
    // pulse shaping
    // ---------------------------------------------------------------
    // high for four cycles, then low: slow enough for the two-flop path,
    // and both clocks stand low between requests
    always @(posedge clk) begin
        ext_n   <= ext_req ? 8 : (ext_n > 0 ? ext_n - 1 : 0);
        aux_n   <= aux_req ? 8 : (aux_n > 0 ? aux_n - 1 : 0);
        ext_pin <= ext_req || ext_n > 5;
        aux_clk <= aux_req || aux_n > 5;
    end
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the timer/counter over classic wishbone.
// assumes 100 MHz clk and a read answer one cycle after the request.
`timescale 1ns/1ps
module tb_top;
    logic        clk     = 1'b0;
    logic        reset   = 1'b1;
    logic [7:0]  adr     = 8'h00;
    logic [31:0] dat_w   = 32'h0;
    logic [31:0] dat_r;
    logic        we      = 1'b0;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        ack;
    logic        ext_req = 1'b0;
    logic        aux_req = 1'b0;
    logic        ext_pin;
    logic        aux_clk;
    logic [1:0]  lvl     = 2'h0;
    logic [1:0]  oe_req  = 2'h0;
    logic [1:0]  pin_oe;
    logic [1:0]  port_rd;
    logic [3:0]  mode    = 4'h0;
    logic        match   = 1'b0;
    logic        irq;
    logic [7:0]  hv;
    logic [7:0]  lv;
    int          n_fail  = 0;
    int          n_checks = 0;
    string       nq[$];
    logic [31:0] eq[$];
    int          tq[$];

    always #5 clk = ~clk;

    tmc_clk_src i_src (.clk(clk), .ext_req(ext_req), .aux_req(aux_req), .ext_pin(ext_pin), .aux_clk(aux_clk));

    tmc_timer i_dut (.clk(clk), .reset(reset), .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .external_clock_pin(ext_pin), .aux_osc_clk(aux_clk), .aux_pin_level(lvl),
        .port_oe_request(oe_req), .aux_pin_oe(pin_oe), .port_read_value(port_rd),
        .capture_compare_mode(mode), .compare_match(match), .overflow_irq(irq));

    // ---------------------------------------------------------------
    // checking and closing
    // ---------------------------------------------------------------
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one access; trig pulses the compare match in the cycle the request is taken
    task automatic wb(logic w, logic [7:0] a, logic [7:0] d, logic trig = 1'b0);
        int i;
        i = 0;
        adr   <= a;
        dat_w <= {24'h0, d};
        we    <= w;
        cyc   <= 1'b1;
        stb   <= 1'b1;
        match <= trig;
        do begin
            @(posedge clk);
            match <= 1'b0;
            i++;
        end while (ack !== 1'b1 && i < 20);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (ack !== 1'b1) begin
            n_fail++;
            close_out();
        end
        @(posedge clk);
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e, string n, int t = 0, logic trig = 1'b0);
        nq.push_back(n);
        eq.push_back(e);
        tq.push_back(t);
        wb(1'b0, a, 8'h00, trig);
    endtask

    task automatic pulse(logic aux, int n);
        repeat (n) begin
            if (aux) aux_req <= 1'b1;
            else ext_req <= 1'b1;
            @(posedge clk);
            aux_req <= 1'b0;
            ext_req <= 1'b0;
            repeat (11) @(posedge clk);
        end
    endtask

    task automatic set_count(logic [7:0] h, logic [7:0] l);
        wb(1'b1, tmc_pkg::OFF_COUNT_HIGH, h);
        wb(1'b1, tmc_pkg::OFF_COUNT_LOW, l);
    endtask

    // read answers are matched against the oldest note; t gives a tolerance
    logic [31:0] m_e;
    int          m_t;
    string       m_n;
    always @(posedge clk) begin
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
            if (eq.size() == 0) begin
                n_fail++;
                $display("Error read note missing");
            end else begin
                m_e = eq.pop_front();
                m_t = tq.pop_front();
                m_n = nq.pop_front();
                chk(m_n, (dat_r + m_t >= m_e && dat_r <= m_e + m_t) ? m_e : dat_r, m_e);
            end
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        close_out();
    end

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'he2d8));
        oe_req <= 2'($urandom);
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 6; a++) rd(8'(a * 4), 32'h0, "reset value");
        $display("test reset done");

        for (int ps = 0; ps < 4; ps++) begin
            wb(1'b1, tmc_pkg::OFF_CONTROL, 8'h00);
            set_count(8'h00, 8'h00);
            wb(1'b1, tmc_pkg::OFF_CONTROL, {2'b00, 2'(ps), 4'h1});
            repeat (256) @(posedge clk);
            wb(1'b1, tmc_pkg::OFF_CONTROL, {2'b00, 2'(ps), 4'h0});
            repeat (20) @(posedge clk);
            rd(tmc_pkg::OFF_COUNT_LOW, 259 / (4 << ps), "timer rate", 1);
        end
        $display("test prescale done");

        set_count(8'hff, 8'hff);
        wb(1'b1, tmc_pkg::OFF_CONTROL, 8'h01);
        repeat (4) @(posedge clk);
        wb(1'b1, tmc_pkg::OFF_CONTROL, 8'h00);
        rd(tmc_pkg::OFF_COUNT_HIGH, 32'h0, "wrap high");
        rd(tmc_pkg::OFF_COUNT_LOW, 32'h1, "wrap low", 1);
        rd(tmc_pkg::OFF_STATUS, 32'h1, "overflow flag");
        chk("irq masked", irq, 1'b0);
        wb(1'b1, tmc_pkg::OFF_ENABLE, 8'h01);
        chk("irq enabled", irq, 1'b1);
        rd(tmc_pkg::OFF_STATUS, 32'h1, "flag held");
        wb(1'b1, tmc_pkg::OFF_STATUS, 8'h01);
        rd(tmc_pkg::OFF_STATUS, 32'h0, "flag cleared");
        chk("irq after clear", irq, 1'b0);
        $display("test overflow done");

        hv = 8'($urandom);
        lv = 8'($urandom);
        wb(1'b1, tmc_pkg::OFF_CONTROL, 8'h80);
        set_count(hv, lv);
        rd(tmc_pkg::OFF_COUNT_LOW, lv, "wide low");
        rd(tmc_pkg::OFF_COUNT_HIGH, hv, "wide high");
        wb(1'b1, tmc_pkg::OFF_COUNT_HIGH, ~hv);
        rd(tmc_pkg::OFF_COUNT_LOW, lv, "low after buffer write");
        rd(tmc_pkg::OFF_COUNT_HIGH, hv, "buffer recaptured");
        wb(1'b1, tmc_pkg::OFF_CONTROL, 8'h00);
        rd(tmc_pkg::OFF_COUNT_HIGH, hv, "live high");
        $display("test wide done");

        set_count(8'h00, 8'h00);
        wb(1'b1, tmc_pkg::OFF_CONTROL, 8'h33);
        pulse(1'b0, 4);
        wb(1'b1, tmc_pkg::OFF_COUNT_HIGH, 8'h00);
        pulse(1'b1, 2);
        pulse(1'b0, 4);
        rd(tmc_pkg::OFF_COUNT_LOW, 32'h1, "prescaler kept");
        $display("test external done");

        lvl <= 2'h3;
        wb(1'b1, tmc_pkg::OFF_CONTROL, 8'h00);
        wb(1'b1, tmc_pkg::OFF_ENABLE, 8'h02);
        set_count(8'h00, 8'h00);
        wb(1'b1, tmc_pkg::OFF_CONTROL, 8'h03);
        repeat (4) @(posedge clk);
        chk("pin enables", pin_oe, 2'h0);
        chk("pin reads", port_rd, 2'h0);
        pulse(1'b1, 3);
        pulse(1'b0, 2);
        rd(tmc_pkg::OFF_COUNT_LOW, 32'h3, "aux count");
        wb(1'b1, tmc_pkg::OFF_ENABLE, 8'h00);
        repeat (4) @(posedge clk);
        chk("pin enables back", pin_oe, oe_req);
        chk("pin reads back", port_rd, 2'h3);
        $display("test aux done");

        // special event only in synchronous mode here
        for (int i = 0; i < 2; i++) begin
            mode <= i ? tmc_pkg::CMP_MODE_SPECIAL : 4'ha;
            set_count(8'hff, 8'hff);
            rd(tmc_pkg::OFF_ENABLE, 32'h0, "enable", 0, 1'b1);
            rd(tmc_pkg::OFF_COUNT_LOW, i ? 32'h0 : 32'hff, "event low");
            rd(tmc_pkg::OFF_COUNT_HIGH, i ? 32'h0 : 32'hff, "event high");
            rd(tmc_pkg::OFF_STATUS, 32'h0, "no flag");
        end
        wb(1'b1, tmc_pkg::OFF_CONTROL, 8'h83);
        wb(1'b1, tmc_pkg::OFF_COUNT_LOW, 8'h55, 1'b1);
        rd(tmc_pkg::OFF_COUNT_LOW, 32'h55, "write beats event");
        wb(1'b1, tmc_pkg::OFF_CONTROL, 8'h07);
        rd(tmc_pkg::OFF_ENABLE, 32'h0, "enable", 0, 1'b1);
        rd(tmc_pkg::OFF_COUNT_LOW, 32'h55, "async ignores event");
        rd(tmc_pkg::OFF_COUNT_HIGH, hv, "event high kept");
        $display("test special event done");

        repeat (5) @(posedge clk);
        if (eq.size() != 0) n_fail++;
        close_out();
    end
endmodule
